/* File: sacr_pkg.sv */
// constants for the shunt amplifier configuration register pair
package sacr_pkg;
  localparam int unsigned REG_W    = 11;
  localparam int unsigned ADDR_W   = 4;

  localparam logic [ADDR_W-1:0] ADDR_AMP_CTRL = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_DRV_CFG  = 4'h7;

  // shunt_amp_control field positions
  localparam int unsigned BIT_INPUT_SEL  = 10;
  localparam int unsigned BIT_REF_HALVE  = 9;
  localparam int unsigned BIT_LOWSIDE_OVERCURRENT_REFERENCE     = 8;
  localparam int unsigned GAIN_HI        = 7;
  localparam int unsigned GAIN_LO        = 6;
  localparam int unsigned BIT_SENSE_DIS  = 5;
  localparam int unsigned BIT_SHORT_A    = 4;
  localparam int unsigned BIT_SHORT_B    = 3;
  localparam int unsigned BIT_SHORT_C    = 2;
  localparam int unsigned TRIP_HI        = 1;
  localparam int unsigned TRIP_LO        = 0;

  // driver_configuration field positions
  localparam int unsigned BIT_CAL_AUTO   = 0;

  // reset: select 0, halve 1, lowside_overcurrent_reference 0, gain 10b, rest 0, trip 11b
  localparam logic [REG_W-1:0] AMP_CTRL_RESET = 11'h283;
  localparam logic [REG_W-1:0] DRV_CFG_RESET  = 11'h000;
  localparam logic [REG_W-1:0] READ_ZERO      = 11'h000;
endpackage

/* File: sacr_word_if.sv */
// write/readback carrier between the register bank and one stored word
`timescale 1ns/10ps
interface sacr_word_if;
  import sacr_pkg::*;
  logic             wr_en;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] value;

  modport owner (input wr_en, input wdata, output value);
  modport user  (output wr_en, output wdata, input value);
endinterface

/* File: sacr_word.sv */
// one 11-bit configuration word with reset value and clock enable
`timescale 1ns/10ps
module sacr_word
  import sacr_pkg::*;
#(
  parameter logic [REG_W-1:0] RESET_VALUE = READ_ZERO
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  sacr_word_if.owner port
);
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      port.value <= RESET_VALUE;
    end else if (ce_i && port.wr_en) begin
      port.value <= port.wdata;
    end
  end
endmodule

/* File: sacr_regs.sv */
// shunt amplifier control and driver configuration register bank
`timescale 1ns/10ps
module sacr_regs
  import sacr_pkg::*;
#(
  parameter bit AMPS_PRESENT = 1'b1
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [REG_W-1:0]  reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [REG_W-1:0]  reg_rdata_o,
  output logic                   reg_rvalid_o,
  output logic                   amp_input_select_o,
  output logic                   ref_halve_o,
  output logic                   lowside_overcurrent_reference_o,
  output logic      [1:0]        amp_gain_select_o,
  output logic                   sense_fault_disable_o,
  output logic                   offset_short_chan_a_o,
  output logic                   offset_short_chan_b_o,
  output logic                   offset_short_chan_c_o,
  output logic      [1:0]        sense_trip_level_o,
  output logic                   cal_auto_o
);
  sacr_word_if amp_if ();
  sacr_word_if cfg_if ();

  logic hit_amp;
  logic hit_cfg;

  // without the amplifiers neither address decodes: writes drop, reads zero
  assign hit_amp = AMPS_PRESENT && (reg_addr_i == ADDR_AMP_CTRL);
  assign hit_cfg = AMPS_PRESENT && (reg_addr_i == ADDR_DRV_CFG);

  assign amp_if.wr_en = reg_wr_i && hit_amp;
  assign cfg_if.wr_en = reg_wr_i && hit_cfg;

  // side effect folded into the stored word so readback shows it too
  always_comb begin
    amp_if.wdata = reg_wdata_i;
    if (reg_wdata_i[BIT_INPUT_SEL]) begin
      amp_if.wdata[BIT_LOWSIDE_OVERCURRENT_REFERENCE] = 1'b1;
    end
  end

  // reserved bits are read/write storage, cleared at reset
  assign cfg_if.wdata = reg_wdata_i;

  sacr_word #(
    .RESET_VALUE (AMP_CTRL_RESET)
  ) u_amp_ctrl (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .port    (amp_if)
  );

  sacr_word #(
    .RESET_VALUE (DRV_CFG_RESET)
  ) u_drv_cfg (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .port    (cfg_if)
  );

  // field outputs registered so downstream analog controls see clean levels
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      amp_input_select_o              <= AMP_CTRL_RESET[BIT_INPUT_SEL];
      ref_halve_o                     <= AMP_CTRL_RESET[BIT_REF_HALVE];
      lowside_overcurrent_reference_o <= AMP_CTRL_RESET[BIT_LOWSIDE_OVERCURRENT_REFERENCE];
      amp_gain_select_o               <= AMP_CTRL_RESET[GAIN_HI:GAIN_LO];
      sense_fault_disable_o           <= AMP_CTRL_RESET[BIT_SENSE_DIS];
      offset_short_chan_a_o           <= AMP_CTRL_RESET[BIT_SHORT_A];
      offset_short_chan_b_o           <= AMP_CTRL_RESET[BIT_SHORT_B];
      offset_short_chan_c_o           <= AMP_CTRL_RESET[BIT_SHORT_C];
      sense_trip_level_o              <= AMP_CTRL_RESET[TRIP_HI:TRIP_LO];
      cal_auto_o                      <= DRV_CFG_RESET[BIT_CAL_AUTO];
    end else if (ce_i) begin
      amp_input_select_o              <= amp_if.value[BIT_INPUT_SEL];
      ref_halve_o                     <= amp_if.value[BIT_REF_HALVE];
      lowside_overcurrent_reference_o <= amp_if.value[BIT_LOWSIDE_OVERCURRENT_REFERENCE];
      amp_gain_select_o               <= amp_if.value[GAIN_HI:GAIN_LO];
      sense_fault_disable_o           <= amp_if.value[BIT_SENSE_DIS];
      offset_short_chan_a_o           <= amp_if.value[BIT_SHORT_A];
      offset_short_chan_b_o           <= amp_if.value[BIT_SHORT_B];
      offset_short_chan_c_o           <= amp_if.value[BIT_SHORT_C];
      sense_trip_level_o              <= amp_if.value[TRIP_HI:TRIP_LO];
      cal_auto_o                      <= cfg_if.value[BIT_CAL_AUTO];
    end
  end

  // read returns stored word one cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o  <= READ_ZERO;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        if (hit_amp) begin
          reg_rdata_o <= amp_if.value;
        end else if (hit_cfg) begin
          reg_rdata_o <= cfg_if.value;
        end else begin
          reg_rdata_o <= READ_ZERO;
        end
      end
    end
  end
endmodule

/* File: sacr_monitor.sv */
// assertions on the register bank ports
`timescale 1ns/10ps
module sacr_monitor import sacr_pkg::*; (
  input wire logic clock_i, rst_i, ce_i, reg_wr_i, reg_rd_i, reg_rvalid_o, cal_auto_o,
  input wire logic amp_input_select_o, lowside_overcurrent_reference_o,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [REG_W-1:0] reg_wdata_i, reg_rdata_o,
  input wire logic [1:0] amp_gain_select_o, sense_trip_level_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire [10:0] w = reg_wdata_i;
  wire wa = ce_i && reg_wr_i && reg_addr_i == ADDR_AMP_CTRL;
  wire wd = ce_i && reg_wr_i && reg_addr_i == ADDR_DRV_CFG;
  // fields trail the stored word by a cycle, so they are judged two edges on
  property p_sel; wa ##1 ce_i |=> amp_input_select_o == $past(w[10], 2); endproperty
  a_sel: assert property (p_sel) else $error("sel");
  property p_ls;
    wa ##1 ce_i |=> lowside_overcurrent_reference_o == $past(w[8] | w[10], 2); endproperty
  a_ls: assert property (p_ls) else $error("ls");
  property p_gn; wa ##1 ce_i |=> amp_gain_select_o == $past(w[7:6], 2); endproperty
  a_gn: assert property (p_gn) else $error("gain");
  property p_tr; wa ##1 ce_i |=> sense_trip_level_o == $past(w[1:0], 2); endproperty
  a_tr: assert property (p_tr) else $error("trip");
  property p_au; wd ##1 ce_i |=> cal_auto_o == $past(w[0], 2); endproperty
  a_au: assert property (p_au) else $error("auto");
  property p_rv; ce_i |=> reg_rvalid_o == $past(reg_rd_i); endproperty
  a_rv: assert property (p_rv) else $error("rvalid");
  property p_un; ce_i && reg_rd_i && reg_addr_i[3:1] != 3'h3 |=> reg_rdata_o == 11'h000;
  endproperty
  a_un: assert property (p_un) else $error("unmapped");
  property p_rb; ce_i && reg_rd_i && reg_addr_i == ADDR_AMP_CTRL && amp_input_select_o
    && $past(ce_i) && !$past(wa) |=> reg_rdata_o[10] && reg_rdata_o[8]; endproperty
  a_rb: assert property (p_rb) else $error("readback");
endmodule
bind sacr_regs sacr_monitor i_sacr_monitor (.*);

/* File: sacr_host.sv */
// stand-in for the controller behind the serial decoder
`timescale 1ns/10ps
module sacr_host import sacr_pkg::*; (
  input  wire logic             clock_i,
  input  wire logic [REG_W-1:0] rdata_i,
  input  wire logic             rvalid_i,
  output logic [ADDR_W-1:0]     addr_o = 4'h0,
  output logic [REG_W-1:0]      wdata_o = 11'h000,
  output logic                  wr_o = 1'b0,
  output logic                  rd_o = 1'b0
);
  // released data is inverted so a stale value never looks valid
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    @(posedge clock_i) {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
    @(posedge clock_i) {wr_o, wdata_o} <= {1'b0, ~d};
  endtask
  task automatic rd(input logic [3:0] a, output logic [10:0] q);
    @(posedge clock_i) {addr_o, rd_o} <= {a, 1'b1};
    @(posedge clock_i) rd_o <= 1'b0;
    // data taken at the edge where the valid pulse is sampled high
    @(posedge clock_i) q = rvalid_i ? rdata_i : 'x;
  endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the register bank
`timescale 1ns/10ps
module testbench;
  import sacr_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  wire [3:0] a;
  wire [10:0] wd, rdata, f;
  wire wr, rd, c, rv;
  logic ce = 1'b1;
  logic [10:0] q, e;
  logic [10:0] v [6] = '{11'h400, 11'h0FF, 11'h2AA, 11'h155, 11'h7FF, 11'h7FE};
  int err_count = 0;
  int n_checks = 0;
  always #2.5 clock_i = ~clock_i;
  sacr_host i_sacr_host (.clock_i, .rdata_i(rdata), .rvalid_i(rv), .addr_o(a), .wdata_o(wd),
    .wr_o(wr), .rd_o(rd));
  sacr_regs i_sacr_regs (.clock_i, .rst_i, .ce_i(ce), .reg_addr_i(a), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rv), .cal_auto_o(c),
    .amp_input_select_o(f[10]), .ref_halve_o(f[9]), .lowside_overcurrent_reference_o(f[8]),
    .amp_gain_select_o(f[7:6]), .sense_fault_disable_o(f[5]), .offset_short_chan_a_o(f[4]),
    .offset_short_chan_b_o(f[3]), .offset_short_chan_c_o(f[2]), .sense_trip_level_o(f[1:0]));
  task automatic chk(input string n, input logic [10:0] x, input logic [10:0] g);
    n_checks++;
    err_count += int'(g !== x);
    if (g !== x) $display("[ERR] %s expected %h seen %h", n, x, g);
  endtask
  task automatic final_report;
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #5000 err_count++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    i_sacr_host.wr(4'h5, 11'h7FF);
    i_sacr_host.rd(ADDR_AMP_CTRL, q);
    chk("amp", 11'h283, q);
    chk("fld", 11'h283, f);
    i_sacr_host.rd(ADDR_DRV_CFG, q);
    chk("drv", 11'h000, q);
    i_sacr_host.rd(4'h5, q);
    chk("unm", 11'h000, q);
    foreach (v[i]) begin
      e = v[i] | {2'b00, v[i][10], 8'h00};
      i_sacr_host.wr(ADDR_AMP_CTRL, v[i]);
      i_sacr_host.wr(ADDR_DRV_CFG, ~v[i]);
      i_sacr_host.rd(ADDR_AMP_CTRL, q);
      chk("amp", e, q);
      chk("fld", e, f);
      i_sacr_host.rd(ADDR_DRV_CFG, q);
      chk("drv", ~v[i], q);
      chk("cal", {10'h000, ~v[i][0]}, {10'h000, c});
    end
    // clock enable low: the write must not land
    @(posedge clock_i) ce <= 1'b0;
    i_sacr_host.wr(ADDR_AMP_CTRL, 11'h000);
    @(posedge clock_i) ce <= 1'b1;
    i_sacr_host.rd(ADDR_AMP_CTRL, q);
    chk("frz", e, q);
    chk("ffz", e, f);
    // mid-run reset brings back the defaults
    @(posedge clock_i) rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    i_sacr_host.rd(ADDR_AMP_CTRL, q);
    chk("rst", AMP_CTRL_RESET, q);
    chk("rfl", AMP_CTRL_RESET, f);
    i_sacr_host.rd(ADDR_DRV_CFG, q);
    chk("rdc", DRV_CFG_RESET, q);
    final_report();
  end
endmodule
